// ---- shared/timer_wdt_map.vh ----
// register offsets, field positions, reset values and timing counts of the timer unit
`ifndef TIMER_WDT_MAP_VH
`define TIMER_WDT_MAP_VH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define TW_ADDR_W          8
`define TW_OFS_CTRL0       8'h00
`define TW_OFS_CTRL1       8'h04
`define TW_OFS_CMP0        8'h08
`define TW_OFS_CMP1        8'h0C
`define TW_OFS_CNT0        8'h10
`define TW_OFS_CNT1        8'h14
`define TW_OFS_IRQ_FLAGS   8'h18
`define TW_OFS_WDT_CTRL    8'h1C
`define TW_OFS_STRIDE      8'h04

// ---------------------------------------------------------------
// timer_control fields
// ---------------------------------------------------------------
`define TW_CTRL_RESET      32'h00000005
`define TW_CTRL_COUNT_RUN  30
`define TW_CTRL_IRQ_ENABLE 29
`define TW_CTRL_MODE_HI    28
`define TW_CTRL_MODE_LO    27
`define TW_CTRL_CLEAR      26
`define TW_CTRL_ACTIVE     25
`define TW_CTRL_PRE_HI     7
`define TW_CTRL_PRE_LO     0

`define TW_MODE_ONESHOT    2'h0
`define TW_MODE_PERIODIC   2'h1
`define TW_MODE_TOGGLE     2'h2
`define TW_MODE_FREE       2'h3

// ---------------------------------------------------------------
// watchdog_control fields
// ---------------------------------------------------------------
`define TW_WDT_RESET       32'h00000400
`define TW_WDT_RESTART     0
`define TW_WDT_RST_FLAG    1
`define TW_WDT_TO_FLAG     2
`define TW_WDT_IRQ_EN      3
`define TW_WDT_SEL_LO      4
`define TW_WDT_SEL_HI      5
`define TW_WDT_TEST        6
`define TW_WDT_ON          7
`define TW_WDT_RST_EN      10
`define TW_WDT_RST_EN_INIT 1'h1

// ---------------------------------------------------------------
// watchdog timing, in watchdog clock cycles
// ---------------------------------------------------------------
`define TW_WDT_DELAY_CYC   14'd1024
`define TW_WDT_HOLD_CYC    14'd16128
`define TW_WDT_LOG2_MIN    5'd14
`define TW_WDT_LOG2_STEP   5'd2

`endif

// ---- rtl/timer_channel.v ----
// one timer channel: prescaler, 32-bit counter and mode handling
`timescale 1ns/1ns
`default_nettype none
`include "timer_wdt_map.vh"

module timer_channel (
   input  wire        i_mclk,
   input  wire        i_rst_b,
   input  wire        i_tick,
   input  wire        i_run,
   input  wire        i_clear,
   input  wire [7:0]  i_prescale,
   input  wire [1:0]  i_mode,
   input  wire [31:0] i_compare,
   output reg  [31:0] o_count,
   output wire        o_timeout,
   output wire        o_stop,
   output reg         o_tout
);

   reg  [7:0]  pre_cnt_q;
   wire        pre_wrap = pre_cnt_q >= i_prescale;
   wire        step     = i_run & i_tick & pre_wrap;
   wire [31:0] count_nx = o_count + 32'h00000001;

   // timeout when the counter reaches the compare value
   assign o_timeout = step & (count_nx == i_compare);
   assign o_stop    = o_timeout & (i_mode == `TW_MODE_ONESHOT);

   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pre_cnt_q <= 8'h00;
         o_count   <= 32'h00000000;
         o_tout    <= 1'b0;
      end else if (i_clear) begin
         pre_cnt_q <= 8'h00;
         o_count   <= 32'h00000000;
      end else if (i_run & i_tick) begin
         // divide by prescale + 1
         pre_cnt_q <= pre_wrap ? 8'h00 : pre_cnt_q + 8'h01;
         if (step) begin
            if (o_timeout && i_mode != `TW_MODE_FREE)
               o_count <= 32'h00000000;
            else
               o_count <= count_nx;
            if (o_timeout && i_mode == `TW_MODE_TOGGLE)
               o_tout <= ~o_tout;
         end
      end
   end

endmodule
`default_nettype wire

// ---- rtl/dual_timer_with_watchdog.v ----
// two-channel timer with watchdog behind an APB slave
`timescale 1ns/1ns
`default_nettype none
`include "timer_wdt_map.vh"

// Summary of operation
// - two channels, each an 8-bit prescaler feeding a 32-bit counter with own irq
// - each channel counts edges of its own crystal-derived clock input
// - channel raises interrupt on timeout; count readable while running
// - watchdog runs freely; two-bit select picks 2^14 to 2^20 cycle timeout
// - enable bit starts watchdog counting from a known state
// - restart bit self-clears and restarts the watchdog count from zero
// - every watchdog timeout sets the timeout flag
// - with reset enabled and no restart, reset follows 1024 cycles later
// - watchdog reset sets reset flag and lasts 16128 cycles
// - with irq and reset off, timeouts still set the flag, no reset
// - test mode bit puts the watchdog into test mode
// - prescaler divides the timer clock by prescale value plus one
// - modes: one-shot, periodic, toggle output, free-running compare
// - with irq enabled, channel interrupts when count equals compare
// - counter clear zeroes prescaler and counter and drops count run
module dual_timer_with_watchdog #(
   parameter [13:0] WDT_DELAY_CYC = `TW_WDT_DELAY_CYC,
   parameter [13:0] WDT_HOLD_CYC  = `TW_WDT_HOLD_CYC,
   parameter [4:0]  WDT_LOG2_MIN  = `TW_WDT_LOG2_MIN
) (
   input  wire        i_mclk,
   input  wire        i_rst_b,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [7:0]  i_paddr,
   input  wire [31:0] i_pwdata,
   output reg  [31:0] o_prdata,
   output wire        o_pready,
   output wire        o_pslverr,
   input  wire        i_timer_clock_in0,
   input  wire        i_timer_clock_in1,
   input  wire        i_wdt_clock_in,
   output wire        o_timer_irq0,
   output wire        o_timer_irq1,
   output wire        o_timer_out0,
   output wire        o_timer_out1,
   output wire        o_wdt_irq,
   output wire        o_wdt_reset
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function hit;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   // interval codes in ascending powers of four
   function [20:0] wdt_interval;
      input [1:0] sel;
      input [4:0] lg_min;
      reg   [4:0] lg;
      begin
         lg = lg_min + `TW_WDT_LOG2_STEP * {3'h0, sel};
         wdt_interval = 21'h000001 << lg;
      end
   endfunction

   localparam [2:0] ST_RUN   = 3'b001;
   localparam [2:0] ST_DELAY = 3'b010;
   localparam [2:0] ST_HOLD  = 3'b100;

   // reset images of the control registers, sliced per field below
   localparam [31:0] CTRL_RST = `TW_CTRL_RESET;
   localparam [31:0] WDT_RST  = `TW_WDT_RESET;

   // ---------------------------------------------------------------
   // pin synchronisers and edge detect
   // ---------------------------------------------------------------
   reg  [2:0] sync1_q;
   reg  [2:0] sync2_q;
   reg  [2:0] sync3_q;
   wire [2:0] rise = sync2_q & ~sync3_q;

   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         sync3_q <= 3'h0;
      end else begin
         sync1_q <= {i_wdt_clock_in, i_timer_clock_in1, i_timer_clock_in0};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire wr       = i_psel & i_penable & i_pwrite;
   wire rd_setup = i_psel & ~i_penable & ~i_pwrite;
   wire mapped   = (i_paddr[7:5] == 3'h0) && (i_paddr[1:0] == 2'h0);
   wire [1:0] wr_ctrl = {wr & hit(i_paddr, `TW_OFS_CTRL1), wr & hit(i_paddr, `TW_OFS_CTRL0)};
   wire [1:0] wr_cmp  = {wr & hit(i_paddr, `TW_OFS_CMP1), wr & hit(i_paddr, `TW_OFS_CMP0)};
   wire wr_flags  = wr & hit(i_paddr, `TW_OFS_IRQ_FLAGS);
   wire wr_wdt    = wr & hit(i_paddr, `TW_OFS_WDT_CTRL);

   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~mapped;

   // ---------------------------------------------------------------
   // timer channels
   // ---------------------------------------------------------------
   reg  [1:0]  run_q;
   reg  [1:0]  ie_q;
   reg  [3:0]  mode_q;
   reg  [15:0] pre_q;
   reg  [63:0] cmp_q;
   reg  [1:0]  flag_q;
   wire [63:0] count_w;
   wire [1:0]  timeout_w;
   wire [1:0]  stop_w;
   wire [1:0]  tout_w;
   integer     i;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : chan
         timer_channel u_chan (
            .i_mclk     (i_mclk),
            .i_rst_b    (i_rst_b),
            .i_tick     (rise[g]),
            .i_run      (run_q[g]),
            .i_clear    (wr_ctrl[g] & i_pwdata[`TW_CTRL_CLEAR]),
            .i_prescale (pre_q[8*g +: 8]),
            .i_mode     (mode_q[2*g +: 2]),
            .i_compare  (cmp_q[32*g +: 32]),
            .o_count    (count_w[32*g +: 32]),
            .o_timeout  (timeout_w[g]),
            .o_stop     (stop_w[g]),
            .o_tout     (tout_w[g])
         );
      end
   endgenerate

   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         run_q  <= {2{CTRL_RST[`TW_CTRL_COUNT_RUN]}};
         ie_q   <= {2{CTRL_RST[`TW_CTRL_IRQ_ENABLE]}};
         mode_q <= {2{CTRL_RST[`TW_CTRL_MODE_HI:`TW_CTRL_MODE_LO]}};
         pre_q  <= {2{CTRL_RST[`TW_CTRL_PRE_HI:`TW_CTRL_PRE_LO]}};
         cmp_q  <= 64'h0000000000000000;
         flag_q <= 2'h0;
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            if (wr_ctrl[i]) begin
               run_q[i] <= i_pwdata[`TW_CTRL_COUNT_RUN] & ~i_pwdata[`TW_CTRL_CLEAR];
               ie_q[i]  <= i_pwdata[`TW_CTRL_IRQ_ENABLE];
               mode_q[2*i +: 2] <= i_pwdata[`TW_CTRL_MODE_HI:`TW_CTRL_MODE_LO];
               pre_q[8*i +: 8]  <= i_pwdata[`TW_CTRL_PRE_HI:`TW_CTRL_PRE_LO];
            end else if (stop_w[i]) begin
               run_q[i] <= 1'b0;
            end
            if (wr_cmp[i])
               cmp_q[32*i +: 32] <= i_pwdata;
            // a timeout in the clearing cycle wins
            flag_q[i] <= (timeout_w[i] & ie_q[i])
                       | (flag_q[i] & ~(wr_flags & i_pwdata[i]));
         end
      end
   end

   assign o_timer_irq0 = flag_q[0];
   assign o_timer_irq1 = flag_q[1];
   assign o_timer_out0 = tout_w[0];
   assign o_timer_out1 = tout_w[1];

   // ---------------------------------------------------------------
   // watchdog
   // ---------------------------------------------------------------
   reg        wdt_on_q;
   reg        wdt_rst_en_q;
   reg        wdt_ie_q;
   reg        wdt_test_q;
   reg [1:0]  wdt_sel_q;
   reg        wdt_tof_q;
   reg        wdt_rsf_q;
   reg [20:0] wdt_cnt_q;
   reg [13:0] wdt_dly_q;
   reg [2:0]  wdt_st_q;

   // test mode counts on every system clock instead of watchdog clock edges
   wire        wdt_tick    = wdt_test_q | rise[2];
   wire        wdt_restart = wr_wdt & i_pwdata[`TW_WDT_RESTART];
   wire        wdt_hold    = wdt_restart | ~wdt_on_q;
   wire [20:0] wdt_last    = wdt_interval(wdt_sel_q, WDT_LOG2_MIN) - 21'h000001;
   wire        wdt_expire  = (wdt_st_q == ST_RUN) & ~wdt_hold & wdt_tick
                             & (wdt_cnt_q == wdt_last);
   wire        wdt_fire    = (wdt_st_q == ST_DELAY) & ~wdt_hold & wdt_tick
                             & (wdt_dly_q == WDT_DELAY_CYC - 14'h0001);

   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wdt_on_q     <= WDT_RST[`TW_WDT_ON];
         wdt_rst_en_q <= `TW_WDT_RST_EN_INIT;
         wdt_ie_q     <= WDT_RST[`TW_WDT_IRQ_EN];
         wdt_test_q   <= WDT_RST[`TW_WDT_TEST];
         wdt_sel_q    <= WDT_RST[`TW_WDT_SEL_HI:`TW_WDT_SEL_LO];
         wdt_tof_q    <= 1'b0;
         wdt_rsf_q    <= 1'b0;
      end else begin
         if (wr_wdt) begin
            wdt_on_q     <= i_pwdata[`TW_WDT_ON];
            wdt_rst_en_q <= i_pwdata[`TW_WDT_RST_EN];
            wdt_ie_q     <= i_pwdata[`TW_WDT_IRQ_EN];
            wdt_test_q   <= i_pwdata[`TW_WDT_TEST];
            wdt_sel_q    <= i_pwdata[`TW_WDT_SEL_HI:`TW_WDT_SEL_LO];
         end
         // sticky flags, write one clears, a new event wins
         wdt_tof_q <= wdt_expire
                    | (wdt_tof_q & ~(wr_wdt & i_pwdata[`TW_WDT_TO_FLAG]));
         wdt_rsf_q <= wdt_fire
                    | (wdt_rsf_q & ~(wr_wdt & i_pwdata[`TW_WDT_RST_FLAG]));
      end
   end

   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wdt_cnt_q <= 21'h000000;
         wdt_dly_q <= 14'h0000;
         wdt_st_q  <= ST_RUN;
      end else begin
         case (wdt_st_q)
            ST_RUN: begin
               if (wdt_hold) begin
                  wdt_cnt_q <= 21'h000000;
               end else if (wdt_expire) begin
                  wdt_cnt_q <= 21'h000000;
                  if (wdt_rst_en_q) begin
                     wdt_dly_q <= 14'h0000;
                     wdt_st_q  <= ST_DELAY;
                  end
               end else if (wdt_tick) begin
                  wdt_cnt_q <= wdt_cnt_q + 21'h000001;
               end
            end
            ST_DELAY: begin
               if (wdt_hold) begin
                  wdt_cnt_q <= 21'h000000;
                  wdt_st_q  <= ST_RUN;
               end else if (wdt_fire) begin
                  wdt_dly_q <= 14'h0000;
                  wdt_st_q  <= ST_HOLD;
               end else if (wdt_tick) begin
                  wdt_dly_q <= wdt_dly_q + 14'h0001;
               end
            end
            ST_HOLD: begin
               if (wdt_tick) begin
                  if (wdt_dly_q == WDT_HOLD_CYC - 14'h0001) begin
                     wdt_cnt_q <= 21'h000000;
                     wdt_st_q  <= ST_RUN;
                  end else begin
                     wdt_dly_q <= wdt_dly_q + 14'h0001;
                  end
               end
            end
            default: begin
               wdt_st_q <= ST_RUN;
            end
         endcase
      end
   end

   assign o_wdt_reset = wdt_st_q[2];
   assign o_wdt_irq   = wdt_tof_q & wdt_ie_q;

   // ---------------------------------------------------------------
   // read data, captured in the setup phase
   // ---------------------------------------------------------------
   reg [31:0] rd_mux;
   wire       rd_ch = (i_paddr == `TW_OFS_CTRL1);

   always @* begin
      rd_mux = 32'h00000000;
      case (i_paddr)
         `TW_OFS_CTRL0, `TW_OFS_CTRL1: begin
            rd_mux[`TW_CTRL_COUNT_RUN] = run_q[rd_ch];
            rd_mux[`TW_CTRL_IRQ_ENABLE] = ie_q[rd_ch];
            rd_mux[`TW_CTRL_MODE_HI:`TW_CTRL_MODE_LO] = mode_q[2*rd_ch +: 2];
            rd_mux[`TW_CTRL_ACTIVE] = run_q[rd_ch];
            rd_mux[`TW_CTRL_PRE_HI:`TW_CTRL_PRE_LO] = pre_q[8*rd_ch +: 8];
         end
         `TW_OFS_CMP0:      rd_mux = cmp_q[31:0];
         `TW_OFS_CMP1:      rd_mux = cmp_q[63:32];
         `TW_OFS_CNT0:      rd_mux = count_w[31:0];
         `TW_OFS_CNT1:      rd_mux = count_w[63:32];
         `TW_OFS_IRQ_FLAGS: rd_mux = {30'h00000000, flag_q};
         `TW_OFS_WDT_CTRL: begin
            rd_mux[`TW_WDT_ON]     = wdt_on_q;
            rd_mux[`TW_WDT_RST_EN] = wdt_rst_en_q;
            rd_mux[`TW_WDT_IRQ_EN] = wdt_ie_q;
            rd_mux[`TW_WDT_TEST]   = wdt_test_q;
            rd_mux[`TW_WDT_SEL_HI:`TW_WDT_SEL_LO] = wdt_sel_q;
            rd_mux[`TW_WDT_TO_FLAG]  = wdt_tof_q;
            rd_mux[`TW_WDT_RST_FLAG] = wdt_rsf_q;
         end
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b)
         o_prdata <= 32'h00000000;
      else if (rd_setup)
         o_prdata <= rd_mux;
   end

endmodule
`default_nettype wire

// ---- verification/dual_timer_with_watchdog_assertions.sv ----
// assertion checker on the ports of the two-channel timer with watchdog
`timescale 1ns/1ns
`default_nettype none
`include "timer_wdt_map.vh"
module dual_timer_with_watchdog_chk #(
   parameter [13:0] WDT_DELAY_CYC = `TW_WDT_DELAY_CYC,
   parameter [13:0] WDT_HOLD_CYC  = `TW_WDT_HOLD_CYC,
   parameter [4:0]  WDT_LOG2_MIN  = `TW_WDT_LOG2_MIN
) (
   input wire logic        i_mclk,
   input wire logic        i_rst_b,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        o_timer_irq0,
   input wire logic        o_timer_irq1,
   input wire logic        o_wdt_irq,
   input wire logic        o_wdt_reset
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   wire        wr_acc = i_psel && i_penable && i_pwrite;
   logic [14:0] hold_q;
   // ---------------------------------------------------------------
   // length of the current watchdog system reset pulse
   // ---------------------------------------------------------------
   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) hold_q <= 15'h0000;
      else if (o_wdt_reset) hold_q <= hold_q + {14'h0000, ~&hold_q};
      else hold_q <= 15'h0000;
   end
   sequence s_wdt_fall;
      o_wdt_reset ##1 !o_wdt_reset;
   endsequence
   property p_pready;
      o_pready;
   endproperty
   property p_err;
      i_psel && i_penable |-> o_pslverr == (i_paddr >= 8'h20 || i_paddr[1:0] != 2'h0);
   endproperty
   property p_err_idle;
      !(i_psel && i_penable) |-> !o_pslverr;
   endproperty
   property p_prdata_hold;
      !(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata);
   endproperty
   property p_irq0_sticky;
      o_timer_irq0 && !(wr_acc && i_paddr == `TW_OFS_IRQ_FLAGS && i_pwdata[0]) |=> o_timer_irq0;
   endproperty
   property p_irq1_sticky;
      o_timer_irq1 && !(wr_acc && i_paddr == `TW_OFS_IRQ_FLAGS && i_pwdata[1]) |=> o_timer_irq1;
   endproperty
   property p_wdt_irq_sticky;
      o_wdt_irq && !(wr_acc && i_paddr == `TW_OFS_WDT_CTRL) |=> o_wdt_irq;
   endproperty
   property p_hold;
      s_wdt_fall |-> hold_q >= WDT_HOLD_CYC;
   endproperty
   a_pready: assert property (p_pready) else $error("pready not high");
   a_err: assert property (p_err) else $error("pslverr does not match address");
   a_err_idle: assert property (p_err_idle) else $error("pslverr outside access phase");
   a_prdata_hold: assert property (p_prdata_hold) else $error("read data changed without read");
   a_irq0_sticky: assert property (p_irq0_sticky) else $error("timer 0 irq dropped");
   a_irq1_sticky: assert property (p_irq1_sticky) else $error("timer 1 irq dropped");
   a_wdt_irq_sticky: assert property (p_wdt_irq_sticky) else $error("watchdog irq lost");
   a_hold: assert property (p_hold) else $error("watchdog reset pulse too short");
endmodule
bind dual_timer_with_watchdog dual_timer_with_watchdog_chk #(
   .WDT_DELAY_CYC(WDT_DELAY_CYC), .WDT_HOLD_CYC(WDT_HOLD_CYC), .WDT_LOG2_MIN(WDT_LOG2_MIN)
) u_chk (
   .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_timer_irq0(o_timer_irq0),
   .o_timer_irq1(o_timer_irq1), .o_wdt_irq(o_wdt_irq), .o_wdt_reset(o_wdt_reset)
);
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking testbench for the two-channel timer with watchdog
`timescale 1ns/1ns
`default_nettype none
`include "timer_wdt_map.vh"
module tb_top;
   logic        i_mclk = 1'b0;
   logic        i_rst_b = 1'b0;
   logic        i_psel = 1'b0;
   logic        i_penable = 1'b0;
   logic        i_pwrite = 1'b0;
   logic [7:0]  i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h00000000;
   logic [2:0]  div_q = 3'h0;
   logic [31:0] rdata;
   logic        err;
   wire  [31:0] o_prdata;
   wire         o_pready, o_pslverr, o_timer_irq0, o_timer_irq1;
   wire         o_timer_out0, o_timer_out1, o_wdt_irq, o_wdt_reset;
   int          n_fail = 0;
   int          tests_run = 0;
   always #10 i_mclk = ~i_mclk;
   // timer clocks: channel 0 and watchdog at mclk/8, channel 1 at mclk/4
   always @(posedge i_mclk) div_q <= div_q + 3'h1;
   dual_timer_with_watchdog #(
      .WDT_DELAY_CYC(14'd4), .WDT_HOLD_CYC(14'd6), .WDT_LOG2_MIN(5'd2)
   ) uut (
      .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_timer_clock_in0(div_q[2]),
      .i_timer_clock_in1(div_q[1]), .i_wdt_clock_in(div_q[2]), .o_timer_irq0(o_timer_irq0),
      .o_timer_irq1(o_timer_irq1), .o_timer_out0(o_timer_out0), .o_timer_out1(o_timer_out1),
      .o_wdt_irq(o_wdt_irq), .o_wdt_reset(o_wdt_reset));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      @(posedge i_mclk);
      rdata = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   function automatic logic sig(input int w);
      case (w)
         0: return o_timer_irq0;
         1: return o_timer_irq1;
         2: return o_wdt_irq;
         default: return o_wdt_reset;
      endcase
   endfunction
   task wait_sig(input int w, input int lim, output int n);
      n = 0;
      while (sig(w) !== 1'b1 && n < lim) begin
         @(posedge i_mclk);
         n++;
      end
   endtask
   task tally_and_finish;
      if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task t_reset_vals;
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk(rdata, i < 2 ? `TW_CTRL_RESET : i == 7 ? `TW_WDT_RESET : 32'h0);
      end
   endtask
   task t_access;
      apb(1'b1, `TW_OFS_CMP1, 32'hA5A55A5A);
      apb(1'b0, `TW_OFS_CMP1, 32'h0);
      chk(rdata, 32'hA5A55A5A);
      apb(1'b1, `TW_OFS_CNT1, 32'hFFFFFFFF);
      apb(1'b0, `TW_OFS_CNT1, 32'h0);
      chk(rdata, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, 8'h02, 32'hFFFFFFFF);
      chk({31'h0, err}, 32'h1);
   endtask
   task t_timer(input int ch, input logic [7:0] pre, input logic [1:0] mode,
                input logic [31:0] cmp);
      logic [7:0] a;
      int n, per, tk;
      a = 8'(ch * 4);
      per = ch ? 4 : 8;
      tk = int'(cmp) * (pre + 1);
      apb(1'b1, a, 32'h04000000);
      apb(1'b0, a, 32'h0);
      chk(rdata, 32'h0);
      apb(1'b0, a + `TW_OFS_CNT0, 32'h0);
      chk(rdata, 32'h0);
      apb(1'b1, a + `TW_OFS_CMP0, cmp);
      apb(1'b1, a, 32'h60000000 | {mode, 27'h0} | pre);
      wait_sig(ch, 4000, n);
      chk({31'h0, n >= (tk - 1) * per && n <= tk * per + 3}, 32'h1);
      apb(1'b0, a, 32'h0);
      chk(rdata, 32'h20000000 | {mode, 27'h0} | pre
                 | (mode != 2'h0 ? 32'h42000000 : 32'h0));
      apb(1'b0, a + `TW_OFS_CNT0, 32'h0);
      chk({31'h0, mode == `TW_MODE_FREE ? rdata >= cmp : rdata < cmp}, 32'h1);
      if (mode == `TW_MODE_TOGGLE)
         chk({31'h0, ch ? o_timer_out1 : o_timer_out0}, 32'h1);
      else
         chk({31'h0, ch ? o_timer_out1 : o_timer_out0}, 32'h0);
      apb(1'b1, `TW_OFS_IRQ_FLAGS, 32'(1 << ch));
      @(negedge i_mclk);
      chk({31'h0, sig(ch)}, 32'h0);
      apb(1'b1, a, 32'h04000000);
   endtask
   task t_wdt(input logic [1:0] sel, input logic tm, ie, ren, kick, input int lo, hi);
      logic [31:0] c;
      int n;
      c = 32'h81 | {ren, 3'h0, tm, sel, ie, 3'h0};
      apb(1'b1, `TW_OFS_WDT_CTRL, 32'h6);
      apb(1'b1, `TW_OFS_WDT_CTRL, c);
      if (kick) begin
         repeat (lo - 6) @(posedge i_mclk);
         apb(1'b1, `TW_OFS_WDT_CTRL, c);
      end
      if (ie || ren) begin
         wait_sig(ren ? 3 : 2, 2000, n);
         chk({31'h0, n >= lo && n <= hi}, 32'h1);
      end else repeat (hi) @(posedge i_mclk);
      if (ren) begin
         for (n = 0; o_wdt_reset === 1'b1 && n < 100; n++) @(posedge i_mclk);
         chk(32'(n), 32'd6);
      end else chk({31'h0, o_wdt_reset}, 32'h0);
      chk({31'h0, o_wdt_irq}, {31'h0, ie});
      apb(1'b0, `TW_OFS_WDT_CTRL, 32'h0);
      chk({29'h0, rdata[2:0]}, {29'h0, 1'b1, ren, 1'b0});
      apb(1'b1, `TW_OFS_WDT_CTRL, 32'h6);
   endtask
   initial begin
      repeat (5) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      t_reset_vals;
      t_access;
      t_timer(0, 8'd1, `TW_MODE_PERIODIC, 32'd3);
      t_timer(1, 8'd0, `TW_MODE_ONESHOT, 32'd4);
      t_timer(0, 8'd0, `TW_MODE_TOGGLE, 32'd3);
      t_timer(1, 8'd2, `TW_MODE_FREE, 32'd2);
      for (int s = 0; s < 4; s++)
         t_wdt(2'(s), 1, 1, 0, 0, (4 << 2 * s) - 1, (4 << 2 * s) + 3);
      t_wdt(2'd1, 1, 1, 0, 1, 15, 19);
      t_wdt(2'd0, 0, 1, 0, 0, 24, 40);
      t_wdt(2'd1, 1, 0, 1, 0, 19, 23);
      t_wdt(2'd0, 1, 0, 0, 0, 0, 40);
      tally_and_finish;
   end
   initial begin
      repeat (40000) @(posedge i_mclk);
      n_fail++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
